/* File: hdl/clock_loss_detect.sv */
// detector for a clock held at one level too long
`timescale 1ns/1ps
module clock_loss_detect import rst_src_pkg::*; #(
  parameter int LIMIT = CLOCK_LOSS_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic system_clock,
  output logic timeout
);
  localparam int CW = $clog2(LIMIT + 1);

  if (LIMIT < 2) begin : g_chk
    $error("clock loss limit too small");
  end

  logic prev_reg;
  logic prev_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic timeout_reg;
  logic timeout_next;

  always_comb begin
    prev_next = system_clock;
    cnt_next = cnt_reg;
    timeout_next = 1'b0;
    if (!enable || system_clock != prev_reg) begin
      cnt_next = '0;
    end else if (cnt_reg == CW'(LIMIT - 1)) begin
      // fires for one cycle, then counts again from zero and refires while the level still holds
      timeout_next = 1'b1;
      cnt_next = '0;
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      cnt_reg <= '0;
      timeout_reg <= 1'b0;
    end else begin
      prev_reg <= prev_next;
      cnt_reg <= cnt_next;
      timeout_reg <= timeout_next;
    end
  end

  assign timeout = timeout_reg;
endmodule

/* File: hdl/rst_src_ctrl.sv */
// reset source controller: sequencing, cause flags and control registers
//
// Contract
// - hold reset, drive pin until supply good, delay
// - power-on exit sets power-on flag
// - other resets clear power-on flag; a monitor reset sets it
// - fetch always restarts at fixed address
// - power-on enables and selects supply monitor
// - low supply with monitor active holds reset
// - only power-on changes monitor enable state
// - monitor reset release has no delay
// - monitor resets only when also selected
// - monitor enable bit 7, sticky, one after power-on
// - bit 6 live supply status, low bits ignored
// - external low pin resets, sets pin flag
// - clock held too long resets when enabled
// - clock-loss bit enables; reads cause flag
// - internal resets leave pin undriven
// - enabled low comparator resets, sets its flag
// - watchdog on after reset, expiry sets flag
// - illegal flash access resets, sets flash flag
// - software bit forces reset, reads one after
// - clock-loss timeout about one hundred microseconds
// - cause flags bits six to zero, seven zero
`timescale 1ns/1ps
module rst_src_ctrl import rst_src_pkg::*; #(
  parameter int POR_DELAY = POR_DELAY_CYCLES,
  parameter int CLOCK_LOSS_LIMIT = CLOCK_LOSS_CYCLES,
  parameter int WDOG_TIMEOUT = WDOG_TIMEOUT_TICKS,
  parameter int HOLD_CYCLES = INT_HOLD_CYCLES
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_n,
  input wire logic comparator_out,
  input wire logic system_clock,
  input wire logic flash_write_enable,
  input wire flash_access_t flash_access,
  input wire logic wdog_service,
  input wire logic wdog_disable,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic core_reset_n,
  output logic [15:0] fetch_start_addr
);

  // ************************************************************
  // sizes and elaboration checks
  // ************************************************************
  localparam int CW = $clog2(POR_DELAY + HOLD_CYCLES + 1);

  if (POR_DELAY < 1 || HOLD_CYCLES < 1) begin : g_chk
    $error("reset delays must be at least one cycle");
  end

  // ************************************************************
  // state
  // ************************************************************
  rst_state_t state_reg;
  rst_state_t state_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;
  logic [CAUSE_W-1:0] cause_reg;
  logic [CAUSE_W-1:0] cause_next;
  logic mon_en_reg;
  logic mon_en_next;
  logic mon_sel_reg;
  logic mon_sel_next;
  logic cmp_en_reg;
  logic cmp_en_next;
  logic clk_en_reg;
  logic clk_en_next;
  logic wd_en_reg;
  logic wd_en_next;
  logic pin_drive_reg;
  logic pin_drive_next;
  logic core_rst_n_reg;
  logic core_rst_n_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [15:0] start_reg;
  logic [15:0] start_next;

  logic clock_lost;
  logic wdog_expire;
  logic flash_err;
  logic monitor_trip;
  logic wr_cause;
  logic wr_monitor;
  logic [CAUSE_W-1:0] trig;

  // ************************************************************
  // helpers
  // ************************************************************
  function automatic logic [CAUSE_W-1:0] cause_only(input int bit_pos);
    logic [CAUSE_W-1:0] v;
    v = CAUSE_NONE;
    v[bit_pos] = 1'b1;
    return v;
  endfunction

  function automatic logic above_user_space(input logic [15:0] addr);
    return addr > FLASH_LIMIT;
  endfunction

  // ************************************************************
  // helper blocks
  // ************************************************************
  clock_loss_detect #(
    .LIMIT(CLOCK_LOSS_LIMIT)
  ) u_clock_loss (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(clk_en_reg && state_reg == ST_RUN),
    .system_clock(system_clock),
    .timeout(clock_lost)
  );

  // watchdog sits idle while the core is in reset, restarting with it
  watchdog_timer #(
    .PRESCALE(WDOG_PRESCALE),
    .TIMEOUT(WDOG_TIMEOUT)
  ) u_watchdog (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(wd_en_reg && state_reg == ST_RUN),
    .service(wdog_service),
    .expire(wdog_expire)
  );

  // ************************************************************
  // reset triggers
  // ************************************************************
  always_comb begin
    flash_err = 1'b0;
    if (flash_access.xdata_write && flash_write_enable &&
        above_user_space(flash_access.addr)) begin
      flash_err = 1'b1;
    end
    if ((flash_access.code_read || flash_access.fetch) &&
        above_user_space(flash_access.addr)) begin
      flash_err = 1'b1;
    end
    if ((flash_access.xdata_write || flash_access.code_read || flash_access.fetch) &&
        flash_access.secure_block) begin
      flash_err = 1'b1;
    end
  end

  assign wr_cause = sfr_wr && sfr_addr == CAUSE_ADDR;
  assign wr_monitor = sfr_wr && sfr_addr == MONITOR_CTRL_ADDR;
  // monitor needs both the enable and the selection to reset
  assign monitor_trip = mon_en_reg && mon_sel_reg && !supply_ok;

  // one bit per source except the monitor, which is checked ahead of these; the priority encoder below picks one
  always_comb begin
    trig = CAUSE_NONE;
    trig[CAUSE_PIN_BIT] = !rst_pin_in;
    trig[CAUSE_CLK_BIT] = clock_lost;
    trig[CAUSE_CMP_BIT] = cmp_en_reg && !comparator_out;
    trig[CAUSE_WDOG_BIT] = wdog_expire;
    trig[CAUSE_FLASH_BIT] = flash_err;
    trig[CAUSE_SOFT_BIT] = wr_cause && sfr_wdata[CAUSE_SOFT_BIT];
  end

  // ************************************************************
  // sequencer and flags
  // ************************************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    cause_next = cause_reg;
    mon_en_next = mon_en_reg;
    mon_sel_next = mon_sel_reg;
    cmp_en_next = cmp_en_reg;
    clk_en_next = clk_en_reg;
    wd_en_next = wd_en_reg;
    case (state_reg)
      ST_POWER: begin
        cnt_next = '0;
        if (supply_ok) begin
          state_next = ST_DELAY;
        end
      end
      ST_DELAY: begin
        if (!supply_ok) begin
          state_next = ST_POWER;
          cnt_next = '0;
        end else if (cnt_reg == CW'(POR_DELAY - 1)) begin
          state_next = ST_RUN;
          cause_next = cause_only(CAUSE_POR_BIT);
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      ST_RUN: begin
        cnt_next = '0;
        if (wr_monitor) begin
          mon_en_next = sfr_wdata[MON_EN_BIT];
        end
        if (wr_cause) begin
          // writing one selects; writing zero drops the selection
          mon_sel_next = sfr_wdata[CAUSE_POR_BIT];
          clk_en_next = sfr_wdata[CAUSE_CLK_BIT];
          cmp_en_next = sfr_wdata[CAUSE_CMP_BIT];
        end
        if (monitor_trip) begin
          state_next = ST_HOLD;
          cause_next = cause_only(CAUSE_POR_BIT);
        end else if (trig != CAUSE_NONE) begin
          state_next = ST_HOLD;
          if (trig[CAUSE_PIN_BIT]) begin
            cause_next = cause_only(CAUSE_PIN_BIT);
          end else if (trig[CAUSE_CLK_BIT]) begin
            cause_next = cause_only(CAUSE_CLK_BIT);
          end else if (trig[CAUSE_CMP_BIT]) begin
            cause_next = cause_only(CAUSE_CMP_BIT);
          end else if (trig[CAUSE_WDOG_BIT]) begin
            cause_next = cause_only(CAUSE_WDOG_BIT);
          end else if (trig[CAUSE_FLASH_BIT]) begin
            cause_next = cause_only(CAUSE_FLASH_BIT);
          end else begin
            cause_next = cause_only(CAUSE_SOFT_BIT);
          end
        end
        if (state_next == ST_HOLD) begin
          // monitor enable and selection survive; comparator and clock-loss enables drop, watchdog enable sets
          cmp_en_next = 1'b0;
          clk_en_next = 1'b0;
          wd_en_next = 1'b1;
        end else if (wdog_disable) begin
          wd_en_next = 1'b0;
        end
      end
      ST_HOLD: begin
        if (cause_reg[CAUSE_POR_BIT]) begin
          if (supply_ok) begin
            state_next = ST_RUN;
          end
        end else if (cause_reg[CAUSE_PIN_BIT]) begin
          if (rst_pin_in) begin
            state_next = ST_RUN;
          end
        end else if (cnt_reg == CW'(HOLD_CYCLES - 1)) begin
          state_next = ST_RUN;
        end else begin
          cnt_next = cnt_reg + CW'(1);
        end
      end
      default: begin
        state_next = ST_POWER;
        cnt_next = '0;
      end
    endcase
  end

  // ************************************************************
  // outputs and register reads
  // ************************************************************
  always_comb begin
    core_rst_n_next = state_next == ST_RUN;
    // pin is pulled only for supply-related resets
    pin_drive_next = state_next == ST_POWER || state_next == ST_DELAY ||
                     (state_next == ST_HOLD && cause_next[CAUSE_POR_BIT]);
    start_next = START_ADDR;
    rdata_next = rdata_reg;
    if (sfr_rd) begin
      if (sfr_addr == MONITOR_CTRL_ADDR) begin
        rdata_next = {mon_en_reg, supply_ok, MON_UNUSED_READ};
      end else if (sfr_addr == CAUSE_ADDR) begin
        rdata_next = {1'b0, cause_reg};
      end else begin
        rdata_next = READ_UNMAPPED;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_reg <= ST_POWER;
      cnt_reg <= '0;
      cause_reg <= CAUSE_NONE;
      mon_en_reg <= 1'b1;
      mon_sel_reg <= 1'b1;
      cmp_en_reg <= 1'b0;
      clk_en_reg <= 1'b0;
      wd_en_reg <= 1'b1;
      pin_drive_reg <= 1'b1;
      core_rst_n_reg <= 1'b0;
      rdata_reg <= READ_UNMAPPED;
      start_reg <= START_ADDR;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cause_reg <= cause_next;
      mon_en_reg <= mon_en_next;
      mon_sel_reg <= mon_sel_next;
      cmp_en_reg <= cmp_en_next;
      clk_en_reg <= clk_en_next;
      wd_en_reg <= wd_en_next;
      pin_drive_reg <= pin_drive_next;
      core_rst_n_reg <= core_rst_n_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
    end
  end

  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = !pin_drive_reg;
  assign core_reset_n = core_rst_n_reg;
  assign fetch_start_addr = start_reg;
  assign sfr_rdata = rdata_reg;

endmodule

/* File: hdl/rst_src_pkg.sv */
// constants, types and register map of the reset source controller
package rst_src_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] MONITOR_CTRL_ADDR = 8'hff;
  localparam logic [7:0] CAUSE_ADDR = 8'hef;
  localparam int MON_EN_BIT = 7;
  localparam int SUPPLY_OK_BIT = 6;
  localparam int CAUSE_FLASH_BIT = 6;
  localparam int CAUSE_CMP_BIT = 5;
  localparam int CAUSE_SOFT_BIT = 4;
  localparam int CAUSE_WDOG_BIT = 3;
  localparam int CAUSE_CLK_BIT = 2;
  localparam int CAUSE_POR_BIT = 1;
  localparam int CAUSE_PIN_BIT = 0;
  localparam int CAUSE_W = 7;
  localparam logic [CAUSE_W-1:0] CAUSE_NONE = 7'h00;
  localparam logic [5:0] MON_UNUSED_READ = 6'h00;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // ************************************************************
  // addresses
  // ************************************************************
  localparam logic [15:0] START_ADDR = 16'h0000;
  localparam logic [15:0] FLASH_LIMIT = 16'h3dff;

  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLOCK_HZ = 40_000_000;
  localparam int CLOCK_LOSS_TIMEOUT_US = 100;
  localparam int CLOCK_LOSS_CYCLES = CLOCK_HZ / 1_000_000 * CLOCK_LOSS_TIMEOUT_US;
  localparam int POR_DELAY_MS = 10;
  localparam int POR_DELAY_CYCLES = CLOCK_HZ / 1000 * POR_DELAY_MS;
  localparam int WDOG_PRESCALE = 12;
  localparam int WDOG_TIMEOUT_TICKS = 256;
  localparam int INT_HOLD_CYCLES = 4;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [3:0] {
    ST_POWER = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_RUN = 4'b0100,
    ST_HOLD = 4'b1000
  } rst_state_t;

  typedef struct packed {
    logic xdata_write;
    logic code_read;
    logic fetch;
    logic secure_block;
    logic [15:0] addr;
  } flash_access_t;

endpackage

/* File: hdl/watchdog_timer.sv */
// watchdog counting mclk divided by the prescale
`timescale 1ns/1ps
module watchdog_timer import rst_src_pkg::*; #(
  parameter int PRESCALE = WDOG_PRESCALE,
  parameter int TIMEOUT = WDOG_TIMEOUT_TICKS
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic service,
  output logic expire
);
  localparam int PW = $clog2(PRESCALE);
  localparam int TW = $clog2(TIMEOUT + 1);

  if (PRESCALE < 2 || TIMEOUT < 2) begin : g_chk
    $error("watchdog prescale or timeout too small");
  end

  logic [PW-1:0] pre_reg;
  logic [PW-1:0] pre_next;
  logic [TW-1:0] tick_reg;
  logic [TW-1:0] tick_next;
  logic expire_reg;
  logic expire_next;

  always_comb begin
    pre_next = pre_reg;
    tick_next = tick_reg;
    expire_next = 1'b0;
    if (!enable || service) begin
      pre_next = '0;
      tick_next = '0;
    end else if (pre_reg == PW'(PRESCALE - 1)) begin
      pre_next = '0;
      if (tick_reg == TW'(TIMEOUT - 1)) begin
        expire_next = 1'b1;
        tick_next = '0;
      end else begin
        tick_next = tick_reg + TW'(1);
      end
    end else begin
      pre_next = pre_reg + PW'(1);
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pre_reg <= '0;
      tick_reg <= '0;
      expire_reg <= 1'b0;
    end else begin
      pre_reg <= pre_next;
      tick_reg <= tick_next;
      expire_reg <= expire_next;
    end
  end

  assign expire = expire_reg;
endmodule

/* File: verification/board_model.sv */
// board model: supply, comparator, observed clock and the pulled-up reset pin
`timescale 1ns/1ps
module board_model (
  input wire logic mclk,
  input wire logic supply_up,
  input wire logic ext_pull_low,
  input wire logic cmp_low,
  input wire logic clk_stop,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  output logic supply_ok,
  output logic rst_pin_in,
  output logic comparator_out,
  output logic system_clock
);
  // pull-up on the pin: either party may pull it low, nobody drives it high
  assign rst_pin_in = !(ext_pull_low || (!rst_pin_oe_n && !rst_pin_out));
  assign supply_ok = supply_up;
  // low when the positive input sits below the negative one
  assign comparator_out = !cmp_low;
  // a stopped clock freezes at its last level, as a dead oscillator would
  initial system_clock = 1'b0;
  always @(posedge mclk) begin
    if (!clk_stop) begin
      system_clock <= !system_clock;
    end
  end
endmodule

/* File: verification/rst_src_chk.sv */
// port checker for the reset source controller, bound to its top module
`timescale 1ns/1ps
module rst_src_chk import rst_src_pkg::*; #(
  parameter int POR_DELAY = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic rst_pin_in,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic core_reset_n,
  input wire logic [15:0] fetch_start_addr
);
  // ****************
  // helper state
  // ****************
  logic por_phase;
  int ok_cnt;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // only the first release after power-on carries the delay
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      por_phase <= 1'b1;
    end else if (core_reset_n) begin
      por_phase <= 1'b0;
    end
  end
  // saturates so a long run cannot wrap it
  always_ff @(posedge mclk) begin
    if (!rst_n || !supply_ok) begin
      ok_cnt <= 0;
    end else if (ok_cnt < 100000) begin
      ok_cnt <= ok_cnt + 1;
    end
  end
  sequence s_soft_req;
    core_reset_n && sfr_wr && sfr_addr == CAUSE_ADDR && sfr_wdata[CAUSE_SOFT_BIT] &&
      supply_ok && rst_pin_in;
  endsequence
  sequence s_internal_hold;
    (!core_reset_n && rst_pin_oe_n) [*4] ##1 (core_reset_n && rst_pin_oe_n);
  endsequence
  // ****************
  // assertions
  // ****************
  AST_PIN_DATA: assert property (rst_pin_out == 1'b0)
    else $error("reset pin data not low");
  AST_FETCH: assert property (fetch_start_addr == START_ADDR)
    else $error("fetch start address moved");
  AST_POR_PIN: assert property (por_phase && !supply_ok |-> !core_reset_n && !rst_pin_oe_n)
    else $error("power-up hold or pin drive missing");
  AST_POR_DELAY: assert property (por_phase && core_reset_n |-> ok_cnt >= POR_DELAY)
    else $error("power-on release too early");
  AST_MON_RELEASE: assert property (!por_phase && !core_reset_n && !rst_pin_oe_n && supply_ok
    |=> core_reset_n && rst_pin_oe_n)
    else $error("monitor reset release delayed");
  AST_SOFT: assert property (s_soft_req |=> s_internal_hold)
    else $error("software reset hold wrong");
  AST_PIN_ENTRY: assert property (core_reset_n && !rst_pin_in && supply_ok && rst_pin_oe_n
    |=> !core_reset_n && rst_pin_oe_n)
    else $error("pin reset not taken");
  AST_MON_READ: assert property (sfr_rd && sfr_addr == MONITOR_CTRL_ADDR && core_reset_n
    |=> sfr_rdata[SUPPLY_OK_BIT] == $past(supply_ok) && sfr_rdata[5:0] == MON_UNUSED_READ)
    else $error("monitor status read wrong");
  AST_CAUSE_TOP: assert property (sfr_rd && sfr_addr == CAUSE_ADDR && core_reset_n
    |=> !sfr_rdata[7])
    else $error("cause bit 7 not zero");
endmodule

bind rst_src_ctrl rst_src_chk #(.POR_DELAY(POR_DELAY)) i_chk (.mclk, .rst_n, .supply_ok,
  .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
  .sfr_rdata, .core_reset_n, .fetch_start_addr);

/* File: verification/tb_rst_src_ctrl.sv */
// self-checking testbench for the reset source controller
`timescale 1ns/1ps
module tb_rst_src_ctrl import rst_src_pkg::*;;
  localparam int POR = 16;
  logic mclk, rst_n, supply_up, ext_pull_low, cmp_low, clk_stop, kick;
  logic supply_ok, rst_pin_in, rst_pin_out, rst_pin_oe_n, comparator_out, system_clock;
  logic flash_write_enable, wdog_service, wdog_disable, sfr_wr, sfr_rd, core_reset_n;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [15:0] fetch_start_addr;
  flash_access_t flash_access;
  int n_errors, n_checks;

  rst_src_ctrl #(.POR_DELAY(POR), .CLOCK_LOSS_LIMIT(20), .WDOG_TIMEOUT(4)) i_dut (
    .mclk, .rst_n, .supply_ok, .rst_pin_in, .rst_pin_out, .rst_pin_oe_n, .comparator_out,
    .system_clock, .flash_write_enable, .flash_access, .wdog_service, .wdog_disable,
    .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .core_reset_n, .fetch_start_addr);
  board_model i_board (.mclk, .supply_up, .ext_pull_low, .cmp_low, .clk_stop, .rst_pin_out,
    .rst_pin_oe_n, .supply_ok, .rst_pin_in, .comparator_out, .system_clock);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // software servicing the watchdog; cleared only by the watchdog scenario
  always @(posedge mclk) wdog_service <= #1 rst_n && kick && !wdog_service;

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge mclk);
    #1;
    sfr_wr = 1'b0;
  endtask
  // read data is registered on the edge that takes the read strobe
  task automatic read_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(posedge mclk);
    #1;
    sfr_rd = 1'b0;
    chk(sfr_rdata, exp);
  endtask
  task automatic wait_core(input logic v, output int n);
    n = 0;
    while (core_reset_n !== v && n < 2000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (core_reset_n !== v) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, core_reset_n, v);
      test_done();
    end
  endtask
  task automatic expect_reset(input logic [7:0] cause);
    int n;
    wait_core(1'b0, n);
    chk({7'h0, rst_pin_oe_n}, 8'h01);
    wait_core(1'b1, n);
    read_chk(CAUSE_ADDR, cause);
  endtask
  task automatic flash_pulse(input logic [19:0] v);
    @(posedge mclk);
    #1;
    flash_write_enable = v[19];
    flash_access = flash_access_t'(v);
    @(posedge mclk);
    #1;
    flash_access = '0;
    flash_write_enable = 1'b0;
  endtask

  // ****************
  // scenarios
  // ****************
  task automatic t_power_on();
    int n;
    repeat (5) @(posedge mclk);
    #1;
    chk({6'h0, core_reset_n, rst_pin_oe_n}, 8'h00);
    supply_up = 1'b1;
    wait_core(1'b1, n);
    chk({7'h0, n >= POR}, 8'h01);
    chk({7'h0, rst_pin_oe_n}, 8'h01);
    chk(fetch_start_addr[15:8], START_ADDR[15:8]);
    chk(fetch_start_addr[7:0], START_ADDR[7:0]);
    read_chk(CAUSE_ADDR, 8'h02);
    read_chk(MONITOR_CTRL_ADDR, 8'hc0);
    sfr_write(MONITOR_CTRL_ADDR, 8'hbf);
    read_chk(MONITOR_CTRL_ADDR, 8'hc0);
    read_chk(8'h10, READ_UNMAPPED);
    $display("power-on test done");
  endtask
  task automatic t_monitor();
    int n;
    supply_up = 1'b0;
    wait_core(1'b0, n);
    repeat (3) @(posedge mclk);
    #1;
    chk({6'h0, core_reset_n, rst_pin_oe_n}, 8'h00);
    supply_up = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
    chk({6'h0, core_reset_n, rst_pin_oe_n}, 8'h03);
    read_chk(CAUSE_ADDR, 8'h02);
    $display("monitor test done");
  endtask
  task automatic t_soft();
    sfr_write(MONITOR_CTRL_ADDR, 8'h00);
    sfr_write(CAUSE_ADDR, 8'h10);
    expect_reset(8'h10);
    read_chk(MONITOR_CTRL_ADDR, 8'h40);
    // monitor enabled but not selected must not reset on a low supply
    sfr_write(MONITOR_CTRL_ADDR, 8'h80);
    supply_up = 1'b0;
    repeat (6) @(posedge mclk);
    #1;
    chk({7'h0, core_reset_n}, 8'h01);
    supply_up = 1'b1;
    sfr_write(CAUSE_ADDR, 8'h02);
    read_chk(MONITOR_CTRL_ADDR, 8'hc0);
    $display("software test done");
  endtask
  task automatic t_pin();
    int n;
    ext_pull_low = 1'b1;
    repeat (6) @(posedge mclk);
    #1;
    chk({6'h0, core_reset_n, rst_pin_oe_n}, 8'h01);
    ext_pull_low = 1'b0;
    wait_core(1'b1, n);
    read_chk(CAUSE_ADDR, 8'h01);
    read_chk(MONITOR_CTRL_ADDR, 8'hc0);
    $display("pin test done");
  endtask
  task automatic t_internal();
    int k;
    int n;
    sfr_write(CAUSE_ADDR, 8'h06);
    clk_stop = 1'b1;
    expect_reset(8'h04);
    clk_stop = 1'b0;
    cmp_low = 1'b1;
    sfr_write(CAUSE_ADDR, 8'h22);
    expect_reset(8'h20);
    cmp_low = 1'b0;
    kick = 1'b0;
    expect_reset(8'h08);
    // a disabled watchdog must stay quiet however long service is missing
    @(posedge mclk);
    #1;
    wdog_disable = 1'b1;
    @(posedge mclk);
    #1;
    wdog_disable = 1'b0;
    n = 0;
    repeat (100) begin
      @(posedge mclk);
      #1;
      n += int'(!core_reset_n);
    end
    chk(8'(n), 8'h00);
    kick = 1'b1;
    flash_pulse({4'b0100, FLASH_LIMIT});
    repeat (4) @(posedge mclk);
    #1;
    chk({7'h0, core_reset_n}, 8'h01);
    for (k = 0; k < 4; k++) begin
      flash_pulse(k == 3 ? {4'b0011, 16'h0100} : {4'b1000 >> k, 16'h3e00});
      expect_reset(8'h40);
    end
    $display("internal sources test done");
  endtask

  initial begin
    rst_n = 1'b0;
    {supply_up, ext_pull_low, cmp_low, clk_stop, wdog_disable} = '0;
    {flash_write_enable, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = '0;
    flash_access = '0;
    kick = 1'b1;
    n_errors = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    t_power_on();
    t_monitor();
    t_soft();
    t_pin();
    t_internal();
    test_done();
  end
endmodule
